// ==== verilog/dmach_pkg.sv ====
// Constants shared by the DMA channel register block and its helper modules.
// Assumes a 32-bit word-addressed register window and a single core clock.
package dmach_pkg;
	localparam logic [7:0] DMACH_OFS_ADDR_LO = 8'h00;
	localparam logic [7:0] DMACH_OFS_ADDR_HI = 8'h04;
	localparam logic [7:0] DMACH_OFS_SIZE = 8'h08;
	localparam logic [7:0] DMACH_OFS_CTRL = 8'h0c;
	localparam logic [7:0] DMACH_OFS_IRQ = 8'h10;
	localparam logic [7:0] DMACH_OFS_MSTR = 8'h14;
	localparam int DMACH_CTRL_BUSY = 31;
	localparam int DMACH_CTRL_RO = 13;
	localparam int DMACH_CTRL_NS = 12;
	localparam int DMACH_CTRL_TC_HI = 10;
	localparam int DMACH_CTRL_TC_LO = 8;
	localparam int DMACH_CTRL_FMT_HI = 6;
	localparam int DMACH_CTRL_FMT_LO = 5;
	localparam int DMACH_CTRL_TYPE_HI = 4;
	localparam int DMACH_CTRL_TYPE_LO = 0;
	localparam logic [31:0] DMACH_CTRL_MASK = 32'h0000_377f;
	localparam int DMACH_IRQ_TC_HI = 14;
	localparam int DMACH_IRQ_TC_LO = 12;
	localparam int DMACH_IRQ_NUM_HI = 8;
	localparam int DMACH_IRQ_NUM_LO = 4;
	localparam int DMACH_IRQ_REQ = 0;
	localparam logic [31:0] DMACH_IRQ_MASK = 32'h0000_71f0;
	localparam int DMACH_MSTR_HI = 14;
	localparam int DMACH_MSTR_LO = 3;
	localparam logic [31:0] DMACH_MSTR_MASK = 32'h0000_7ff8;
	localparam logic [31:0] DMACH_RESET_WORD = 32'h0000_0000;
	localparam logic [4:0] DMACH_TYPE_MEM = 5'h00;
	localparam logic [31:0] DMACH_BYTES_PER_REQ = 32'h0000_0004;
	localparam int DMACH_FIFO_DEPTH = 16;
	localparam int DMACH_REQ_WIDTH = 64;
endpackage : dmach_pkg

// ==== verilog/dmach_fifo.sv ====
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; depth is a power of two.
`timescale 1ns/10ps
module dmach_fifo #(
	parameter int WIDTH = 64,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Fill side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	// Drain side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW:0] wr_ptr_reg;
	logic [AW:0] rd_ptr_reg;
	wire full_w = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
	wire empty_w = (wr_ptr_reg == rd_ptr_reg);
	wire push_w = in_valid_i && !full_w;
	wire pop_w = out_ready_i && !empty_w;
	assign in_ready_o = !full_w;
	assign out_valid_o = !empty_w;
	assign out_data_o = mem_reg[rd_ptr_reg[AW-1:0]];
	always_ff @(posedge clk_i)
	begin
		if (push_w)
			mem_reg[wr_ptr_reg[AW-1:0]] <= in_data_i;
	end
	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end
		else
		begin
			if (push_w)
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			if (pop_w)
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
		end
	end
endmodule : dmach_fifo

// ==== verilog/dmach_irq.sv ====
// Interrupt message requester: MSI when enabled, legacy message otherwise.
// Assumes the link side accepts a request with an acknowledge handshake.
`timescale 1ns/10ps
module dmach_irq (
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Trigger and settings
	input wire logic trig_i,
	input wire logic msi_en_i,
	input wire logic [2:0] tc_i,
	input wire logic [4:0] num_i,
	// Link request
	output logic msi_req_o,
	output logic legacy_req_o,
	output logic [2:0] msi_tc_o,
	output logic [4:0] msi_num_o,
	input wire logic irq_ack_i,
	output logic busy_o
);
	logic msi_reg;
	logic leg_reg;
	logic [2:0] tc_reg;
	logic [4:0] num_reg;
	wire idle_w = !msi_reg && !leg_reg;
	wire take_w = trig_i && idle_w;
	assign msi_req_o = msi_reg;
	assign legacy_req_o = leg_reg;
	assign msi_tc_o = tc_reg;
	assign msi_num_o = num_reg;
	assign busy_o = !idle_w;
	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			msi_reg <= 1'b0;
			leg_reg <= 1'b0;
			tc_reg <= 3'h0;
			num_reg <= 5'h00;
		end
		else if (take_w)
		begin
			msi_reg <= msi_en_i;
			leg_reg <= !msi_en_i;
			tc_reg <= tc_i;
			num_reg <= num_i;
		end
		else if (irq_ack_i)
		begin
			msi_reg <= 1'b0;
			leg_reg <= 1'b0;
		end
	end
endmodule : dmach_irq

// ==== verilog/dmach_top.sv ====
// DMA channel register block: header settings, interrupt request, master address.
// Assumes a word register port decoded from the base window and a link requester.
`timescale 1ns/10ps
module dmach_top #(
	parameter int DEPTH = dmach_pkg::DMACH_FIFO_DEPTH
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Register port
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [3:0] reg_be_i,
	input wire logic [31:0] reg_wdata_i,
	output logic [31:0] reg_rdata_o,
	output logic reg_rvalid_o,
	// Endpoint configuration
	input wire logic msi_en_i,
	// Request stream toward the transaction layer
	output logic req_valid_o,
	input wire logic req_ready_i,
	output logic [63:0] req_data_o,
	// Interrupt request toward the transaction layer
	output logic msi_req_o,
	output logic legacy_req_o,
	output logic [2:0] msi_tc_o,
	output logic [4:0] msi_num_o,
	input wire logic irq_ack_i,
	// Local master memory address of the current request
	output logic [14:0] local_addr_o
);
	typedef enum logic [1:0] {
		DMACH_IDLE = 2'b00,
		DMACH_RUN = 2'b01,
		DMACH_DRAIN = 2'b10
	} dmach_state_type;

	dmach_state_type state_reg;
	dmach_state_type state_next;
	logic [31:0] addr_lo_reg;
	logic [31:0] addr_hi_reg;
	logic [31:0] size_reg;
	logic [31:0] ctrl_reg;
	logic [31:0] irq_reg;
	logic [31:0] mstr_reg;
	logic [31:0] remain_reg;
	logic [31:0] remain_next;
	logic [14:0] laddr_reg;
	logic [14:0] laddr_next;
	logic [31:0] paddr_reg;
	logic [31:0] paddr_next;
	logic [31:0] rdata_reg;
	logic rvalid_reg;
	logic [63:0] hdr_w;
	logic fifo_ready_w;
	logic fifo_empty_n_w;

	// Address decode.
	wire sel_lo_w = (reg_addr_i == dmach_pkg::DMACH_OFS_ADDR_LO);
	wire sel_hi_w = (reg_addr_i == dmach_pkg::DMACH_OFS_ADDR_HI);
	wire sel_size_w = (reg_addr_i == dmach_pkg::DMACH_OFS_SIZE);
	wire sel_ctrl_w = (reg_addr_i == dmach_pkg::DMACH_OFS_CTRL);
	wire sel_irq_w = (reg_addr_i == dmach_pkg::DMACH_OFS_IRQ);
	wire sel_mstr_w = (reg_addr_i == dmach_pkg::DMACH_OFS_MSTR);
	wire [31:0] be_mask_w = {{8{reg_be_i[3]}}, {8{reg_be_i[2]}}, {8{reg_be_i[1]}}, {8{reg_be_i[0]}}};
	wire busy_w = (state_reg != DMACH_IDLE);
	wire start_w = reg_wr_i && sel_ctrl_w && (reg_be_i != 4'h0) && !busy_w;
	wire irq_trig_w = reg_wr_i && sel_irq_w && reg_be_i[0] && reg_wdata_i[dmach_pkg::DMACH_IRQ_REQ];

	// Header fields taken from the control register.
	wire ro_w = ctrl_reg[dmach_pkg::DMACH_CTRL_RO];
	wire ns_w = ctrl_reg[dmach_pkg::DMACH_CTRL_NS];
	wire [2:0] tc_w =
		ctrl_reg[dmach_pkg::DMACH_CTRL_TC_HI:dmach_pkg::DMACH_CTRL_TC_LO];
	wire [1:0] fmt_w =
		ctrl_reg[dmach_pkg::DMACH_CTRL_FMT_HI:dmach_pkg::DMACH_CTRL_FMT_LO];
	wire [4:0] type_w =
		ctrl_reg[dmach_pkg::DMACH_CTRL_TYPE_HI:dmach_pkg::DMACH_CTRL_TYPE_LO];
	wire is_4dw_w = fmt_w[0];
	wire [31:0] addr_word_w = is_4dw_w ? addr_hi_reg : paddr_reg;

	// Header word: fmt, type, tc, attributes, then the address word.
	assign hdr_w = {
		1'b0,
		fmt_w,
		type_w,
		1'b0,
		tc_w,
		4'h0,
		2'b00,
		ro_w,
		ns_w,
		12'h000,
		addr_word_w
	};

	// Sequencing: one header per four bytes of the remaining length.
	wire push_w = (state_reg == DMACH_RUN) && fifo_ready_w;
	wire last_w = (remain_reg <= dmach_pkg::DMACH_BYTES_PER_REQ);
	wire [31:0] remain_dec_w = last_w ? 32'h0000_0000
		: remain_reg - dmach_pkg::DMACH_BYTES_PER_REQ;
	wire [31:0] paddr_inc_w = paddr_reg + dmach_pkg::DMACH_BYTES_PER_REQ;
	wire [14:0] laddr_inc_w = laddr_reg + 15'(dmach_pkg::DMACH_BYTES_PER_REQ);
	wire zero_len_w = (size_reg == 32'h0000_0000);

	// Local start address: master register bits above, link address bits below.
	wire [11:0] laddr_hi_w =
		mstr_reg[dmach_pkg::DMACH_MSTR_HI:dmach_pkg::DMACH_MSTR_LO];
	wire [2:0] laddr_lo_w = addr_lo_reg[2:0];
	wire [14:0] laddr_start_w = {laddr_hi_w, laddr_lo_w};

	// Read values with reserved bits masked to zero.
	wire [31:0] status_w = {busy_w, 31'h0};
	wire [31:0] rd_ctrl_w = (ctrl_reg & dmach_pkg::DMACH_CTRL_MASK) | status_w;
	wire [31:0] rd_irq_w = irq_reg & dmach_pkg::DMACH_IRQ_MASK;
	wire [31:0] rd_mstr_w = mstr_reg & dmach_pkg::DMACH_MSTR_MASK;
	wire [31:0] rmux_w = sel_lo_w ? addr_lo_reg :
		sel_hi_w ? addr_hi_reg :
		sel_size_w ? size_reg :
		sel_ctrl_w ? rd_ctrl_w :
		sel_irq_w ? rd_irq_w :
		sel_mstr_w ? rd_mstr_w :
		32'h0000_0000;

	always_comb
	begin
		state_next = state_reg;
		remain_next = remain_reg;
		laddr_next = laddr_reg;
		paddr_next = paddr_reg;
		case (state_reg)
			DMACH_IDLE:
			begin
				if (start_w)
				begin
					remain_next = size_reg;
					paddr_next = addr_lo_reg;
					laddr_next = laddr_start_w;
					if (zero_len_w)
					begin
						state_next = DMACH_DRAIN;
					end
					else
					begin
						state_next = DMACH_RUN;
					end
				end
			end
			DMACH_RUN:
			begin
				if (push_w)
				begin
					remain_next = remain_dec_w;
					paddr_next = paddr_inc_w;
					laddr_next = laddr_inc_w;
					if (last_w)
					begin
						state_next = DMACH_DRAIN;
					end
				end
			end
			DMACH_DRAIN:
			begin
				if (!fifo_empty_n_w)
				begin
					state_next = DMACH_IDLE;
				end
			end
			default:
			begin
				state_next = DMACH_IDLE;
			end
		endcase
	end

	// Operation state and counters.
	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			state_reg <= DMACH_IDLE;
		else
			state_reg <= state_next;
	end

	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			remain_reg <= dmach_pkg::DMACH_RESET_WORD;
		else
			remain_reg <= remain_next;
	end

	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			laddr_reg <= 15'h0000;
		else
			laddr_reg <= laddr_next;
	end

	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			paddr_reg <= dmach_pkg::DMACH_RESET_WORD;
		else
			paddr_reg <= paddr_next;
	end

	// Write strobes; all but the interrupt register freeze while an operation runs.
	wire wr_lo_w = reg_wr_i && sel_lo_w && !busy_w;
	wire wr_hi_w = reg_wr_i && sel_hi_w && !busy_w;
	wire wr_size_w = reg_wr_i && sel_size_w && !busy_w;
	wire wr_ctrl_w = reg_wr_i && sel_ctrl_w && !busy_w;
	wire wr_irq_w = reg_wr_i && sel_irq_w;
	wire wr_mstr_w = reg_wr_i && sel_mstr_w && !busy_w;

	// Byte-lane merge of the write data; reserved bits are never stored.
	wire [31:0] lo_merge_w = (addr_lo_reg & ~be_mask_w) | (reg_wdata_i & be_mask_w);
	wire [31:0] hi_merge_w = (addr_hi_reg & ~be_mask_w) | (reg_wdata_i & be_mask_w);
	wire [31:0] size_merge_w = (size_reg & ~be_mask_w) | (reg_wdata_i & be_mask_w);
	wire [31:0] ctrl_merge_w = ((ctrl_reg & ~be_mask_w) | (reg_wdata_i & be_mask_w))
		& dmach_pkg::DMACH_CTRL_MASK;
	wire [31:0] irq_merge_w = ((irq_reg & ~be_mask_w) | (reg_wdata_i & be_mask_w))
		& dmach_pkg::DMACH_IRQ_MASK;
	wire [31:0] mstr_merge_w = ((mstr_reg & ~be_mask_w) | (reg_wdata_i & be_mask_w))
		& dmach_pkg::DMACH_MSTR_MASK;

	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			addr_lo_reg <= dmach_pkg::DMACH_RESET_WORD;
		else if (wr_lo_w)
			addr_lo_reg <= lo_merge_w;
	end

	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			addr_hi_reg <= dmach_pkg::DMACH_RESET_WORD;
		else if (wr_hi_w)
			addr_hi_reg <= hi_merge_w;
	end

	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			size_reg <= dmach_pkg::DMACH_RESET_WORD;
		else if (wr_size_w)
			size_reg <= size_merge_w;
	end

	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			ctrl_reg <= dmach_pkg::DMACH_RESET_WORD;
		else if (wr_ctrl_w)
			ctrl_reg <= ctrl_merge_w;
	end

	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			irq_reg <= dmach_pkg::DMACH_RESET_WORD;
		else if (wr_irq_w)
			irq_reg <= irq_merge_w;
	end

	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			mstr_reg <= dmach_pkg::DMACH_RESET_WORD;
		else if (wr_mstr_w)
			mstr_reg <= mstr_merge_w;
	end

	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			rdata_reg <= 32'h0000_0000;
			rvalid_reg <= 1'b0;
		end
		else
		begin
			rvalid_reg <= reg_rd_i;
			if (reg_rd_i)
				rdata_reg <= rmux_w;
		end
	end

	assign reg_rdata_o = rdata_reg;
	assign reg_rvalid_o = rvalid_reg;
	assign local_addr_o = laddr_reg;

	// Interrupt settings use the freshly written word so one write suffices.
	dmach_irq u_irq (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.trig_i(irq_trig_w),
		.msi_en_i(msi_en_i),
		.tc_i(reg_wdata_i[dmach_pkg::DMACH_IRQ_TC_HI:dmach_pkg::DMACH_IRQ_TC_LO]),
		.num_i(reg_wdata_i[dmach_pkg::DMACH_IRQ_NUM_HI:dmach_pkg::DMACH_IRQ_NUM_LO]),
		.msi_req_o(msi_req_o),
		.legacy_req_o(legacy_req_o),
		.msi_tc_o(msi_tc_o),
		.msi_num_o(msi_num_o),
		.irq_ack_i(irq_ack_i),
		.busy_o()
	);

	// Request headers queue toward the link.
	dmach_fifo #(
		.WIDTH(dmach_pkg::DMACH_REQ_WIDTH),
		.DEPTH(DEPTH)
	) u_fifo (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.in_valid_i(push_w),
		.in_ready_o(fifo_ready_w),
		.in_data_i(hdr_w),
		.out_valid_o(fifo_empty_n_w),
		.out_ready_i(req_ready_i),
		.out_data_o(req_data_o)
	);

	assign req_valid_o = fifo_empty_n_w;
endmodule : dmach_top

// ==== test/dmach_props.sv ====
// Port checker for the DMA channel register block.
// Assumes it is bound to dmach_top and shares its single clock.
`timescale 1ns/10ps
module dmach_props (
	// Clock and register port
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [3:0] reg_be_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic [31:0] reg_rdata_o,
	input wire logic reg_rvalid_o,
	// Link side
	input wire logic msi_en_i,
	input wire logic req_valid_o,
	input wire logic req_ready_i,
	input wire logic [63:0] req_data_o,
	input wire logic msi_req_o,
	input wire logic legacy_req_o,
	input wire logic [2:0] msi_tc_o,
	input wire logic [4:0] msi_num_o,
	input wire logic irq_ack_i
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	wire pend = msi_req_o || legacy_req_o;
	wire trig = reg_wr_i && reg_addr_i == 8'h10 && reg_be_i[0] && reg_wdata_i[0] && !pend;
	a_irq_resv_zero: assert property (reg_rd_i && reg_addr_i == 8'h10 |=> reg_rvalid_o
		&& reg_rdata_o[31:15] == 17'h0 && reg_rdata_o[11:9] == 3'h0 && reg_rdata_o[3:0] == 4'h0)
		else $error("interrupt register reserved bits not zero");
	a_mstr_resv_zero: assert property (reg_rd_i && reg_addr_i == 8'h14 |=> reg_rvalid_o
		&& reg_rdata_o[31:15] == 17'h0 && reg_rdata_o[2:0] == 3'h0)
		else $error("master address reserved bits not zero");
	a_ctrl_resv_zero: assert property (reg_rd_i && reg_addr_i == 8'h0c |=>
		reg_rdata_o[30:14] == 17'h0 && !reg_rdata_o[11] && !reg_rdata_o[7])
		else $error("control reserved bits not zero");
	a_msi_send: assert property (trig && msi_en_i |=> msi_req_o && !legacy_req_o)
		else $error("trigger did not raise msi request");
	a_legacy_send: assert property (trig && !msi_en_i |=> legacy_req_o && !msi_req_o)
		else $error("trigger did not raise legacy request");
	a_msi_fields: assert property (trig |=> msi_tc_o == $past(reg_wdata_i[14:12])
		&& msi_num_o == $past(reg_wdata_i[8:4])) else $error("msi class or number wrong");
	a_irq_held: assert property (pend && !irq_ack_i |=>
		$stable({msi_req_o, legacy_req_o, msi_tc_o, msi_num_o})) else $error("request not held");
	a_irq_cleared: assert property (irq_ack_i |=> !msi_req_o && !legacy_req_o)
		else $error("request not cleared by ack");
	a_hdr_held: assert property (req_valid_o && !req_ready_i |=>
		req_valid_o && $stable(req_data_o)) else $error("header changed while stalled");
	cover property (trig && msi_en_i);
	cover property (trig && !msi_en_i);
	cover property (req_valid_o && !req_ready_i);
endmodule : dmach_props
bind dmach_top dmach_props i_dmach_props (.clk_i, .sys_rst_i, .reg_wr_i, .reg_rd_i,
	.reg_addr_i, .reg_be_i, .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o, .msi_en_i,
	.req_valid_o, .req_ready_i, .req_data_o, .msi_req_o, .legacy_req_o, .msi_tc_o,
	.msi_num_o, .irq_ack_i);

// ==== test/dmach_link_model.sv ====
// Link-side model: takes request headers and acknowledges interrupt messages.
// Assumes the bench raises stall_i to hold requests back.
`timescale 1ns/10ps
module dmach_link_model (
	// Clock and control
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic stall_i,
	// Request stream and interrupt
	input wire logic valid_i,
	output logic ready_o,
	input wire logic [63:0] data_i,
	input wire logic msi_i,
	input wire logic leg_i,
	output logic ack_o
);
	logic [63:0] hdr_q[$];
	int msi_n = 0;
	int leg_n = 0;
	int wait_n;
	assign ready_o = !stall_i;
	always @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			ack_o <= 1'b0;
			wait_n <= 0;
		end
		else
		begin
			if (valid_i && ready_o)
				hdr_q.push_back(data_i);
			if (wait_n == 2)
			begin
				msi_n <= msi_n + int'(msi_i);
				leg_n <= leg_n + int'(leg_i);
			end
			ack_o <= wait_n == 2 && (msi_i || leg_i);
			wait_n <= (msi_i || leg_i) && wait_n < 3 ? wait_n + 1 : 0;
		end
	end
endmodule : dmach_link_model

// ==== test/tb_top.sv ====
// Bench for the DMA channel register block with a link-side model.
// Assumes the one-cycle strobe register port of dmach_top.
`timescale 1ns/10ps
module tb_top;
	logic clk_i = 0, sys_rst_i = 1, reg_wr_i = 0, reg_rd_i = 0, msi_en_i = 0, stall = 0;
	logic [7:0] reg_addr_i = 0;
	logic [3:0] reg_be_i = 0;
	logic [31:0] reg_wdata_i = 0, rd_v, a;
	logic [13:0] c;
	logic [63:0] h;
	wire logic [31:0] reg_rdata_o;
	wire logic [63:0] req_data_o;
	wire logic [14:0] local_addr_o;
	wire logic [2:0] msi_tc_o;
	wire logic [4:0] msi_num_o;
	wire logic reg_rvalid_o, req_valid_o, req_ready_i, msi_req_o, legacy_req_o, irq_ack_i;
	int bad_count = 0, checks = 0, n;
	logic [7:0] offs[4] = '{8'h0c, 8'h10, 8'h14, 8'h18};
	dmach_top #(.DEPTH(16)) i_dmach_top (.clk_i, .sys_rst_i, .reg_wr_i, .reg_rd_i,
		.reg_addr_i, .reg_be_i, .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o, .msi_en_i,
		.req_valid_o, .req_ready_i, .req_data_o, .msi_req_o, .legacy_req_o, .msi_tc_o,
		.msi_num_o, .irq_ack_i, .local_addr_o);
	dmach_link_model i_dmach_link_model (.clk_i, .sys_rst_i, .stall_i(stall),
		.valid_i(req_valid_o), .ready_o(req_ready_i), .data_i(req_data_o),
		.msi_i(msi_req_o), .leg_i(legacy_req_o), .ack_o(irq_ack_i));
	initial forever #12.5 clk_i = ~clk_i;
	task chk(string nm, logic [63:0] s, logic [63:0] e);
		checks++;
		if (s !== e)
		begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task wr(logic [7:0] ad, logic [3:0] be, logic [31:0] d);
		@(negedge clk_i);
		{reg_wr_i, reg_addr_i, reg_be_i, reg_wdata_i} = {1'b1, ad, be, d};
		@(negedge clk_i);
		reg_wr_i = 0;
	endtask : wr
	task rd(logic [7:0] ad, output logic [31:0] v);
		@(negedge clk_i);
		{reg_rd_i, reg_addr_i} = {1'b1, ad};
		@(negedge clk_i);
		reg_rd_i = 0;
		v = reg_rdata_o;
	endtask : rd
	task close_out;
		if (bad_count == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : close_out
	initial
	begin
		#(25 * 20000);
		bad_count++;
		close_out;
	end
	initial
	begin
		repeat (6) @(negedge clk_i);
		sys_rst_i = 0;
		foreach (offs[i])
		begin
			rd(offs[i], rd_v);
			chk("reset", rd_v, 0);
		end
		wr(8'h14, 4'hf, 32'hffff_ffff);
		rd(8'h14, rd_v);
		chk("mstr", rd_v, 32'h0000_7ff8);
		wr(8'h10, 4'hf, 32'hffff_fffe);
		rd(8'h10, rd_v);
		chk("irq", rd_v, 32'h0000_71f0);
		wr(8'h14, 4'hf, 32'h0000_0128);
		wr(8'h00, 4'hf, 32'h0000_1005);
		wr(8'h04, 4'hf, 32'h0000_0002);
		wr(8'h08, 4'hf, 32'h0000_0010);
		wr(8'h0c, 4'h0, 32'h0000_0060);
		rd(8'h0c, rd_v);
		chk("nostart", rd_v[31], 0);
		for (int f = 0; f < 4; f++)
		begin
			n = f == 3 ? 20 : f + 1;
			stall = 1;
			wr(8'h08, 4'hf, f == 3 ? 80 : 4 * f + 1);
			c = {f[0], ~f[0], 1'b0, 3'(f + 3), 1'b0, 2'(f), 5'h00};
			wr(8'h0c, 4'hf, {18'h0, c});
			chk("laddr", local_addr_o, 15'h012d);
			wr(8'h0c, 4'hf, 32'h0000_0700);
			rd(8'h0c, rd_v);
			chk("busy", rd_v, {1'b1, 17'h0, c});
			stall = 0;
			for (int k = 0; k < 100 && rd_v[31]; k++)
				rd(8'h0c, rd_v);
			chk("done", rd_v[31], 0);
			chk("count", i_dmach_link_model.hdr_q.size(), n);
			chk("lend", local_addr_o, 15'h012d + 15'(4 * n));
			foreach (i_dmach_link_model.hdr_q[j])
			begin
				h = i_dmach_link_model.hdr_q[j];
				a = f[0] ? 32'h2 : 32'h1005 + 4 * j;
				chk("hdr", {h[62:56], h[54:52], h[45:44], h[31:0]},
					{2'(f), 5'h0, 3'(f + 3), f[0], ~f[0], a});
			end
			i_dmach_link_model.hdr_q.delete();
		end
		for (int m = 0; m < 2; m++)
		begin
			msi_en_i = m[0];
			wr(8'h10, 4'h3, 32'h0000_3051);
			chk("tcnum", {msi_tc_o, msi_num_o}, {3'h3, 5'h05});
			repeat (8) @(negedge clk_i);
			chk("msi", i_dmach_link_model.msi_n, m);
			chk("leg", i_dmach_link_model.leg_n, 1);
		end
		rd(8'h10, rd_v);
		chk("irqrd", rd_v, 32'h0000_3050);
		close_out;
	end
endmodule : tb_top
